// *** hdl/rtcc_mode_decode.sv ***
// Decode of the operation-mode field into packet format selects
`default_nettype none
module rtcc_mode_decode
   import rtcc_pkg::*;
(
   input  wire logic [1:0] mode_field,
   output logic            basic_fixed,
   output logic            basic_variable,
   output logic            auto_mode,
   output logic [3:0]      header_bits
);
   assign basic_fixed    = (mode_field == RTCC_MODE_FIXED);
   assign basic_variable = (mode_field == RTCC_MODE_VAR);
   assign auto_mode      = mode_field[1];
   assign header_bits    = (mode_field == RTCC_MODE_AUTO9)  ? RTCC_HDR_NINE :
                           (mode_field == RTCC_MODE_AUTO10) ? RTCC_HDR_TEN  :
                           RTCC_HDR_NONE;
endmodule // rtcc_mode_decode
`default_nettype wire

// *** hdl/rtcc_pkg.sv ***
// Constants and types of the radio task-control configuration block
`default_nettype none
package rtcc_pkg;
   localparam int unsigned RTCC_ADDR_W = 16;
   localparam int unsigned RTCC_DATA_W = 8;
   localparam logic [15:0] RTCC_TASK_CONF_OFS = 16'h6001;
   localparam logic [15:0] RTCC_STATUS_OFS    = 16'h6010;
   localparam logic [7:0]  RTCC_TASK_CONF_RST = 8'h00;
   // Field positions inside task_control_config
   localparam int unsigned RTCC_MODE_LSB   = 0;
   localparam int unsigned RTCC_REPEAT_BIT = 2;
   localparam int unsigned RTCC_START_BIT  = 3;
   localparam int unsigned RTCC_STOP_LSB   = 4;
   localparam int unsigned RTCC_CCPOL_BIT  = 6;
   localparam int unsigned RTCC_RPTBHV_BIT = 7;
   // Operation modes
   localparam logic [1:0] RTCC_MODE_FIXED = 2'h0;
   localparam logic [1:0] RTCC_MODE_VAR   = 2'h1;
   localparam logic [1:0] RTCC_MODE_AUTO9 = 2'h2;
   localparam logic [1:0] RTCC_MODE_AUTO10 = 2'h3;
   localparam logic [3:0] RTCC_HDR_NONE  = 4'h0;
   localparam logic [3:0] RTCC_HDR_NINE  = 4'h9;
   localparam logic [3:0] RTCC_HDR_TEN   = 4'ha;
   // Timer stop policies
   localparam logic [1:0] RTCC_STOP_NONE  = 2'h0;
   localparam logic [1:0] RTCC_STOP_AFTER = 2'h1;
   localparam logic [1:0] RTCC_STOP_ABORT = 2'h2;
   localparam logic [1:0] RTCC_STOP_FIRST = 2'h3;
   // Task end causes
   localparam logic [2:0] RTCC_END_NONE  = 3'h0;
   localparam logic [2:0] RTCC_END_OK    = 3'h1;
   localparam logic [2:0] RTCC_END_STOP  = 3'h2;
   localparam logic [2:0] RTCC_END_ABORT = 3'h3;
   localparam logic [2:0] RTCC_END_BUSY  = 3'h4;
   typedef enum logic [5:0] {
      RTCC_ST_IDLE   = 6'h01,
      RTCC_ST_CAL    = 6'h02,
      RTCC_ST_TRIG   = 6'h04,
      RTCC_ST_LISTEN = 6'h08,
      RTCC_ST_SEARCH = 6'h10,
      RTCC_ST_ACTIVE = 6'h20
   } rtcc_state_t;
endpackage
`default_nettype wire

// *** hdl/rtcc_stop_policy.sv ***
// Timer event 2 stop decision for the running task
`default_nettype none
module rtcc_stop_policy
   import rtcc_pkg::*;
(
   input  wire logic [1:0] stop_sel,
   input  wire logic       event2,
   input  wire logic       busy,
   input  wire logic       waiting,
   input  wire logic       in_active,
   input  wire logic       in_first,
   output logic            end_now,
   output logic            abort_now,
   output logic            end_after
);
   wire is_after = (stop_sel == RTCC_STOP_AFTER);
   wire is_first = (stop_sel == RTCC_STOP_FIRST);
   // Sync search and waits end at once, a packet in flight is let finish
   assign end_now   = event2 & ((is_after & waiting) | (is_first & in_first));
   assign end_after = event2 & is_after & in_active;
   assign abort_now = event2 & busy & (stop_sel == RTCC_STOP_ABORT);
endmodule // rtcc_stop_policy
`default_nettype wire

// *** hdl/rtcc_task_control.sv ***
// Task-control configuration register and the task sequencer it steers
// Operation
// - Mode 00 runs basic fixed-length, 01 basic variable-length packets.
// - Mode 10 runs automatic mode with 9-bit header, 11 with 10-bit.
// - Start bit clear starts at once; set waits for timer event 1.
// - Stop 01: event 2 ends after current packet, at once when waiting.
// - Stop 10: event 2 aborts transmit or receive immediately.
// - Stop 11: event 2 ends task only in first search or assessment.
// - Policy clear: keep listening until signal drops below level, then transmit.
// - Policy set: end the task when measured signal is above level.
// - Repeat behaviour clear listens before every repeat; set listens only first.
// - Repeated receive: clear recalibrates each listen; set calibrates once.
`default_nettype none
module rtcc_task_control
   import rtcc_pkg::*;
(
   input  wire logic                   core_clk,
   input  wire logic                   rst_b,
   input  wire logic [RTCC_ADDR_W-1:0] reg_addr,
   input  wire logic [RTCC_DATA_W-1:0] reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [RTCC_DATA_W-1:0] reg_rdata,
   input  wire logic                   task_start,
   input  wire logic                   task_is_tx,
   input  wire logic                   task_cc,
   input  wire logic                   cal_done,
   input  wire logic                   timer_event1,
   input  wire logic                   timer_event2,
   input  wire logic                   rssi_valid,
   input  wire logic                   rssi_below,
   input  wire logic                   sync_found,
   input  wire logic                   packet_done,
   output logic                        parameter_lock_first,
   output logic                        mode_basic_fixed,
   output logic                        mode_basic_variable,
   output logic                        mode_auto,
   output logic      [3:0]             header_bits,
   output logic                        cal_req,
   output logic                        listen_en,
   output logic                        search_en,
   output logic                        active_en,
   output logic                        active_tx,
   output logic                        task_end,
   output logic      [2:0]             end_cause
);
   logic [7:0]       config_reg;
   logic [7:0]       config_next;
   rtcc_state_t      state_reg;
   rtcc_state_t      state_next;
   logic             tx_reg;
   logic             cc_reg;
   logic             first_reg;
   logic             listened_reg;
   logic             pend_reg;
   logic             end_reg;
   logic [2:0]       cause_reg;
   logic [2:0]       cause_next;
   logic [7:0]       rdata_reg;
   logic [7:0]       rdata_next;

   // Field views of the configuration
   wire [1:0] mode_f    = config_reg[RTCC_MODE_LSB +: 2];
   wire       repeat_f  = config_reg[RTCC_REPEAT_BIT];
   wire       start_f   = config_reg[RTCC_START_BIT];
   wire [1:0] stop_f    = config_reg[RTCC_STOP_LSB +: 2];
   wire       ccpol_f   = config_reg[RTCC_CCPOL_BIT];
   wire       rptbhv_f  = config_reg[RTCC_RPTBHV_BIT];

   // Register decode
   wire hit_conf   = (reg_addr == RTCC_TASK_CONF_OFS);
   wire hit_status = (reg_addr == RTCC_STATUS_OFS);
   wire wr_conf    = reg_wr & hit_conf;

   // State views
   wire st_idle   = (state_reg == RTCC_ST_IDLE);
   wire st_cal    = (state_reg == RTCC_ST_CAL);
   wire st_trig   = (state_reg == RTCC_ST_TRIG);
   wire st_listen = (state_reg == RTCC_ST_LISTEN);
   wire st_search = (state_reg == RTCC_ST_SEARCH);
   wire st_active = (state_reg == RTCC_ST_ACTIVE);
   wire busy      = ~st_idle;
   wire waiting   = st_cal | st_trig | st_search | st_listen;
   wire in_first  = first_reg & (st_search | st_listen);

   logic end_now;
   logic abort_now;
   logic end_after;

   rtcc_mode_decode u_mode (
      .mode_field     (mode_f),
      .basic_fixed    (mode_basic_fixed),
      .basic_variable (mode_basic_variable),
      .auto_mode      (mode_auto),
      .header_bits    (header_bits)
   );

   rtcc_stop_policy u_stop (
      .stop_sel  (stop_f),
      .event2    (timer_event2),
      .busy      (busy),
      .waiting   (waiting),
      .in_active (st_active),
      .in_first  (in_first),
      .end_now   (end_now),
      .abort_now (abort_now),
      .end_after (end_after)
   );

   // Listening is skipped on repeats only when the repeat behaviour says so
   wire need_listen = cc_reg & (~listened_reg | ~rptbhv_f);
   wire [5:0] run_st = ~tx_reg      ? RTCC_ST_SEARCH :
                       need_listen  ? RTCC_ST_LISTEN : RTCC_ST_ACTIVE;
   wire [5:0] entry_st = start_f ? RTCC_ST_TRIG : run_st;

   // Ordinary progress, before any stop
   wire cca_ok   = st_listen & rssi_valid & rssi_below;
   wire cca_busy = st_listen & rssi_valid & ~rssi_below & ccpol_f;
   wire pkt_end  = st_active & packet_done;
   // An event 2 in the very cycle the packet completes still ends the task
   wire stop_due = pend_reg | end_after;
   wire fin_ok   = pkt_end & ~stop_due & ~repeat_f;
   wire fin_pend = pkt_end & stop_due;
   wire recal    = pkt_end & ~stop_due & repeat_f & ~tx_reg & ~rptbhv_f;
   wire fin_stop = end_now | fin_pend;
   wire fin_any  = abort_now | fin_stop | fin_ok | cca_busy;

   always_comb begin
      state_next = state_reg;
      cause_next = cause_reg;
      if (abort_now) begin
         state_next = RTCC_ST_IDLE;
         cause_next = RTCC_END_ABORT;
      end else if (fin_stop) begin
         state_next = RTCC_ST_IDLE;
         cause_next = RTCC_END_STOP;
      end else begin
         unique case (state_reg)
            RTCC_ST_IDLE: begin
               if (task_start) begin
                  state_next = RTCC_ST_CAL;
                  cause_next = RTCC_END_NONE;
               end
            end
            RTCC_ST_CAL: begin
               if (cal_done) begin
                  state_next = rtcc_state_t'(entry_st);
               end
            end
            RTCC_ST_TRIG: begin
               if (timer_event1) begin
                  state_next = rtcc_state_t'(run_st);
               end
            end
            RTCC_ST_LISTEN: begin
               if (cca_ok) begin
                  state_next = RTCC_ST_ACTIVE;
               end else if (cca_busy) begin
                  state_next = RTCC_ST_IDLE;
                  cause_next = RTCC_END_BUSY;
               end
            end
            RTCC_ST_SEARCH: begin
               if (sync_found) begin
                  state_next = RTCC_ST_ACTIVE;
               end
            end
            RTCC_ST_ACTIVE: begin
               if (fin_ok) begin
                  state_next = RTCC_ST_IDLE;
                  cause_next = RTCC_END_OK;
               end else if (recal) begin
                  state_next = RTCC_ST_CAL;
               end else if (pkt_end) begin
                  state_next = rtcc_state_t'(entry_st);
               end
            end
            default: begin
               state_next = RTCC_ST_IDLE;
            end
         endcase
      end
   end

   // The engine has no write path into the entry, only the host does
   assign config_next = wr_conf ? reg_wdata : config_reg;
   assign rdata_next  = ~reg_rd    ? 8'h00 :
                        hit_conf   ? config_reg :
                        hit_status ? {busy, first_reg, listened_reg, pend_reg, 1'b0, cause_reg} :
                        8'h00;

   // Reset value is only a safe default, software still sets the entry up
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         config_reg <= RTCC_TASK_CONF_RST;
         rdata_reg  <= 8'h00;
      end else begin
         config_reg <= config_next;
         rdata_reg  <= rdata_next;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= RTCC_ST_IDLE;
         cause_reg <= RTCC_END_NONE;
         end_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         cause_reg <= cause_next;
         end_reg   <= busy & fin_any;
      end
   end

   // Task attributes are caught at start so a mid-task pin change is harmless
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_reg <= 1'b0;
         cc_reg <= 1'b0;
      end else if (st_idle & task_start) begin
         tx_reg <= task_is_tx;
         cc_reg <= task_cc;
      end
   end

   // First phase ends when the first search or assessment is left
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         first_reg <= 1'b0;
      end else if (st_idle) begin
         first_reg <= task_start;
      end else if ((st_search | st_listen) & (state_next != state_reg)) begin
         first_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         listened_reg <= 1'b0;
      end else if (st_idle) begin
         listened_reg <= 1'b0;
      end else if (cca_ok) begin
         listened_reg <= 1'b1;
      end
   end

   // Deferred stop is held until the packet in flight completes
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_reg <= 1'b0;
      end else if (st_idle) begin
         pend_reg <= 1'b0;
      end else if (end_after & ~packet_done) begin
         pend_reg <= 1'b1;
      end else if (pkt_end) begin
         pend_reg <= 1'b0;
      end
   end

   assign reg_rdata            = rdata_reg;
   assign parameter_lock_first = busy;
   assign cal_req              = st_cal;
   assign listen_en            = st_listen;
   assign search_en            = st_search;
   assign active_en            = st_active;
   assign active_tx            = st_active & tx_reg;
   assign task_end             = end_reg;
   assign end_cause            = cause_reg;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_deferred;
      st_active & timer_event2 & (stop_f == RTCC_STOP_AFTER) & ~packet_done;
   endsequence

   sequence s_pkt_close;
      pkt_end & ~abort_now;
   endsequence

   sequence s_tx_repeat;
      pkt_end & repeat_f & tx_reg & cc_reg & ~start_f & ~abort_now & ~fin_stop;
   endsequence

   chk_mode_basic: assert property (
      (mode_f == RTCC_MODE_FIXED |-> mode_basic_fixed & ~mode_auto) and
      (mode_f == RTCC_MODE_VAR |-> mode_basic_variable & ~mode_auto))
      else $error("basic mode decode wrong");

   chk_mode_header: assert property (
      mode_f[1] |-> mode_auto && header_bits == (mode_f[0] ? 4'ha : 4'h9))
      else $error("auto mode header length wrong");

   chk_start_trig: assert property (
      st_cal & cal_done & ~abort_now & ~fin_stop |=> (st_trig == start_f))
      else $error("start trigger not honoured");

   chk_stop_pending: assert property (
      s_deferred |=> pend_reg && st_active)
      else $error("deferred stop not held while packet runs");

   chk_stop_deferred: assert property (
      (pend_reg | end_after) ##0 s_pkt_close
      |=> task_end && end_cause == RTCC_END_STOP && st_idle)
      else $error("deferred stop not applied at packet end");

   chk_stop_abort: assert property (
      busy & timer_event2 & (stop_f == RTCC_STOP_ABORT)
      |=> st_idle & task_end & (end_cause == RTCC_END_ABORT))
      else $error("immediate abort missing");

   chk_stop_first: assert property (
      busy & timer_event2 & (stop_f == RTCC_STOP_FIRST) & ~in_first
      |=> end_cause != RTCC_END_STOP)
      else $error("stop after first phase");

   chk_cca_listen: assert property (
      st_listen & rssi_valid & ~rssi_below & ~ccpol_f & ~timer_event2 |=> st_listen)
      else $error("listening left while channel busy");

   chk_cca_busy: assert property (
      st_listen & rssi_valid & ~rssi_below & ccpol_f & ~timer_event2
      |=> task_end ##0 (end_cause == RTCC_END_BUSY) ##1 ~task_end)
      else $error("busy channel did not end task");

   chk_cc_listen_once: assert property (
      s_tx_repeat ##0 (rptbhv_f & listened_reg) |=> st_active)
      else $error("repeat listened again after first transmission");

   chk_cc_listen_each: assert property (
      s_tx_repeat ##0 ~rptbhv_f |=> st_listen)
      else $error("repeat transmitted without listening");

   chk_rx_recal: assert property (
      recal & ~timer_event2 |=> st_cal ##0 cal_req)
      else $error("repeated receive did not recalibrate");

   chk_single_end: assert property (
      pkt_end & ~repeat_f & ~abort_now & ~fin_stop
      |=> st_idle && task_end && end_cause == RTCC_END_OK)
      else $error("single operation did not end after packet");

   chk_cfg_hold: assert property (
      ~wr_conf |=> $stable(config_reg))
      else $error("configuration changed without host write");

endmodule // rtcc_task_control
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the task-control configuration block
`default_nettype none
module tb_top
   import rtcc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0;
   logic        rst_b    = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_rdata;
   logic        task_is_tx = 1'b0;
   logic        task_cc = 1'b0;
   logic        rssi_below = 1'b0;
   logic        cal_lvl = 1'b0;
   logic [6:0]  ev = 7'h00;
   logic        lock, fixed_m, var_m, auto_m, cal_req, listen_en, search_en, active_en, active_tx, task_end;
   logic [3:0]  header_bits;
   logic [2:0]  end_cause;
   logic [3:0]  st;
   logic [3:0]  seen;
   logic        rd_d = 1'b0;
   logic [7:0]  rd_q[$];
   logic [2:0]  end_q[$];
   int          num_errors = 0;
   int          n_tests = 0;
   int          seed = 32'hacf6;
   // Event bits: start, cal, ev1, ev2, rssi, sync, packet
   localparam logic [6:0] E_ST = 7'h40, E_CAL = 7'h20, E_EV1 = 7'h10, E_EV2 = 7'h08;
   localparam logic [6:0] E_RSSI = 7'h04, E_SYNC = 7'h02, E_PKT = 7'h01;
   assign st = {active_en, search_en, listen_en, cal_req};
   always #4 core_clk = ~core_clk;
   rtcc_task_control DUT (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .task_start(ev[6]), .task_is_tx(task_is_tx),
      .task_cc(task_cc), .cal_done(ev[5] | cal_lvl), .timer_event1(ev[4]), .timer_event2(ev[3]),
      .rssi_valid(ev[2]), .rssi_below(rssi_below), .sync_found(ev[1]), .packet_done(ev[0]),
      .parameter_lock_first(lock), .mode_basic_fixed(fixed_m), .mode_basic_variable(var_m),
      .mode_auto(auto_m), .header_bits(header_bits), .cal_req(cal_req), .listen_en(listen_en),
      .search_en(search_en), .active_en(active_en), .active_tx(active_tx), .task_end(task_end),
      .end_cause(end_cause));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      if (rd_q.size() + end_q.size() != 0) num_errors++;
      if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Scoreboard: results are taken at the falling edge, where they have settled
   always @(posedge core_clk) rd_d <= reg_rd;
   always @(negedge core_clk) begin
      if (rd_d === 1'b1) begin
         if (rd_q.size() == 0) num_errors++;
         else chk(reg_rdata, rd_q.pop_front());
      end
      if (task_end === 1'b1) begin
         if (end_q.size() == 0) num_errors++;
         else chk({5'h00, end_cause}, {5'h00, end_q.pop_front()});
      end
   end
   // Every driver task ends on a falling edge, so strobes never collide
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
      @(posedge core_clk) reg_wr <= 1'b0;
      @(negedge core_clk);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      rd_q.push_back(exp);
      @(posedge core_clk) begin reg_addr <= a; reg_rd <= 1'b1; end
      @(posedge core_clk) reg_rd <= 1'b0;
      @(negedge core_clk);
   endtask
   task automatic pulse(input logic [6:0] m);
      @(posedge core_clk) ev <= m;
      @(posedge core_clk) ev <= 7'h00;
      @(negedge core_clk);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic start(input logic tx, input logic cc, input logic [2:0] cause);
      end_q.push_back(cause);
      @(posedge core_clk) begin task_is_tx <= tx; task_cc <= cc; ev <= E_ST; end
      @(posedge core_clk) ev <= 7'h00;
      @(negedge core_clk);
      chk({7'h00, lock}, 8'h01);
   endtask
   // Bounded wait for one sequencer output; seen collects all outputs met on the way
   task automatic wait_st(input int i);
      int k;
      seen = 4'h0;
      for (k = 0; k < 30 && st[i] !== 1'b1; k++) begin
         @(negedge core_clk);
         seen |= st;
      end
      chk({7'h00, st[i]}, 8'h01);
   endtask
   task automatic wait_end();
      int k;
      for (k = 0; k < 40 && task_end !== 1'b1; k++) @(negedge core_clk);
      chk({7'h00, task_end}, 8'h01);
      chk({7'h00, lock}, 8'h00);
   endtask
   task automatic rx_to_active();
      wait_st(0);
      pulse(E_CAL);
      wait_st(2);
      pulse(E_SYNC);
      wait_st(3);
      chk({7'h00, active_tx}, 8'h00);
   endtask
   function automatic logic [7:0] cfg(input logic [1:0] m, input logic rp, input logic sb,
                                      input logic [1:0] sp, input logic pol, input logic rb);
      return {rb, pol, sp, sb, rp, m};
   endfunction
   initial begin
      logic [7:0] d;
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      rd(RTCC_TASK_CONF_OFS, 8'h00);
      rd(RTCC_STATUS_OFS, 8'h00);
      for (int m = 0; m < 4; m++) begin
         d = $random(seed);
         d[1:0] = m;
         wr(RTCC_TASK_CONF_OFS, d);
         chk({4'h0, fixed_m, var_m, auto_m, 1'b0}, {4'h0, m == 0, m == 1, m >= 2, 1'b0});
         chk({4'h0, header_bits}, (m == 2) ? 8'h09 : (m == 3) ? 8'h0a : 8'h00);
         rd(RTCC_TASK_CONF_OFS, d);
      end
      d = $random(seed);
      wr(16'h1234, d);
      rd(16'h1234, 8'h00);
      wr(RTCC_STATUS_OFS, d);
      rd(RTCC_STATUS_OFS, 8'h00);
      // Single receive runs once then releases the lock
      wr(RTCC_TASK_CONF_OFS, cfg(2'h0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
      start(1'b0, 1'b0, RTCC_END_OK);
      rx_to_active();
      pulse(E_PKT);
      wait_end();
      // Timer start, and stop field 00 ignores event 2
      wr(RTCC_TASK_CONF_OFS, cfg(2'h1, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0));
      start(1'b0, 1'b0, RTCC_END_OK);
      wait_st(0);
      pulse(E_CAL);
      idle(5);
      chk({7'h00, search_en}, 8'h00);
      pulse(E_EV1);
      wait_st(2);
      pulse(E_EV2);
      idle(3);
      chk({7'h00, search_en}, 8'h01);
      pulse(E_SYNC);
      wait_st(3);
      pulse(E_PKT);
      wait_end();
      // Stop 01 while searching ends at once, while active after the packet
      wr(RTCC_TASK_CONF_OFS, cfg(2'h0, 1'b0, 1'b0, 2'h1, 1'b0, 1'b0));
      start(1'b0, 1'b0, RTCC_END_STOP);
      wait_st(0);
      pulse(E_CAL);
      wait_st(2);
      pulse(E_EV2);
      chk({7'h00, task_end}, 8'h01);
      start(1'b0, 1'b0, RTCC_END_STOP);
      rx_to_active();
      pulse(E_EV2);
      idle(2);
      chk({7'h00, active_en}, 8'h01);
      pulse(E_PKT);
      wait_end();
      // Stop 10 aborts a packet in flight
      wr(RTCC_TASK_CONF_OFS, cfg(2'h0, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0));
      start(1'b0, 1'b0, RTCC_END_ABORT);
      rx_to_active();
      pulse(E_EV2);
      chk({7'h00, active_en}, 8'h00);
      wait_end();
      // Stop 11 acts in the first search only
      wr(RTCC_TASK_CONF_OFS, cfg(2'h0, 1'b0, 1'b0, 2'h3, 1'b0, 1'b0));
      start(1'b0, 1'b0, RTCC_END_STOP);
      wait_st(0);
      pulse(E_CAL);
      wait_st(2);
      pulse(E_EV2);
      wait_end();
      wr(RTCC_TASK_CONF_OFS, cfg(2'h0, 1'b1, 1'b0, 2'h3, 1'b0, 1'b1));
      start(1'b0, 1'b0, RTCC_END_STOP);
      rx_to_active();
      pulse(E_PKT);
      wait_st(2);
      chk({7'h00, seen[0]}, 8'h00);
      pulse(E_EV2);
      idle(3);
      chk({7'h00, search_en}, 8'h01);
      // Nothing stops this task now; a reset in mid-run ends it with no task_end
      @(posedge core_clk) rst_b <= 1'b0;
      void'(end_q.pop_back());
      idle(2);
      chk({6'h00, lock, search_en}, 8'h00);
      @(posedge core_clk) rst_b <= 1'b1;
      rd(RTCC_TASK_CONF_OFS, RTCC_TASK_CONF_RST);
      rd(RTCC_STATUS_OFS, 8'h00);
      // Repeated receive with recalibration before each listen
      wr(RTCC_TASK_CONF_OFS, cfg(2'h0, 1'b1, 1'b0, 2'h1, 1'b0, 1'b0));
      start(1'b0, 1'b0, RTCC_END_STOP);
      rx_to_active();
      pulse(E_PKT);
      wait_st(0);
      pulse(E_CAL);
      wait_st(2);
      pulse(E_EV2);
      wait_end();
      // Clear-channel transmit keeps listening while the channel is busy
      wr(RTCC_TASK_CONF_OFS, cfg(2'h0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
      start(1'b1, 1'b1, RTCC_END_OK);
      wait_st(0);
      pulse(E_CAL);
      wait_st(1);
      @(posedge core_clk) rssi_below <= 1'b0;
      pulse(E_RSSI);
      idle(2);
      chk({7'h00, listen_en}, 8'h01);
      @(posedge core_clk) rssi_below <= 1'b1;
      pulse(E_RSSI);
      wait_st(3);
      chk({7'h00, active_tx}, 8'h01);
      pulse(E_PKT);
      wait_end();
      // Policy set gives up on a busy channel
      wr(RTCC_TASK_CONF_OFS, cfg(2'h0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0));
      start(1'b1, 1'b1, RTCC_END_BUSY);
      wait_st(0);
      pulse(E_CAL);
      wait_st(1);
      @(posedge core_clk) rssi_below <= 1'b0;
      pulse(E_RSSI);
      wait_end();
      // Repeated clear-channel transmit, listen once, then listen every time
      for (int rb = 1; rb >= 0; rb--) begin
         wr(RTCC_TASK_CONF_OFS, cfg(2'h0, 1'b1, 1'b0, 2'h1, 1'b0, rb[0]));
         @(posedge core_clk) begin cal_lvl <= 1'b1; rssi_below <= 1'b1; end
         start(1'b1, 1'b1, RTCC_END_STOP);
         wait_st(1);
         pulse(E_RSSI);
         wait_st(3);
         pulse(E_PKT);
         if (rb == 1) begin
            wait_st(3);
            chk({7'h00, seen[1]}, 8'h00);
            pulse(E_EV2);
            idle(2);
            pulse(E_PKT);
         end else begin
            wait_st(1);
            pulse(E_EV2);
         end
         wait_end();
         @(posedge core_clk) cal_lvl <= 1'b0;
      end
      idle(4);
      end_sim();
   end
   initial begin
      #200000;
      num_errors++;
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
